/* rtl/dpa_pkg.sv */
// shared types and constants for the dot-product accumulate unit
package dpa_pkg;
  // ----------------------------------------
  // widths and fixed-point constants
  // ----------------------------------------
  localparam int unsigned DPA_WORD_W = 32;
  localparam int unsigned DPA_HALF_W = 16;
  localparam int unsigned DPA_ACC_W = 64;
  localparam int unsigned DPA_ACC_NUM = 4;
  localparam int unsigned DPA_SEL_W = 2;
  localparam logic [15:0] DPA_Q15_MINUS_ONE = 16'h8000;
  localparam logic [31:0] DPA_Q31_MAX = 32'h7fff_ffff;
  localparam logic [63:0] DPA_SAT_POS = 64'h0000_0000_7fff_ffff;
  localparam logic [63:0] DPA_SAT_NEG = 64'hffff_ffff_8000_0000;
  localparam logic [63:0] DPA_ACC_RST = 64'h0000_0000_0000_0000;

  // ----------------------------------------
  // operations, one-hot
  // ----------------------------------------
  typedef enum logic [4:0] {
    DPA_OP_FRAC_DOT = 5'h01,
    DPA_OP_FRAC_CROSS = 5'h02,
    DPA_OP_FRAC_CROSS_SAT = 5'h04,
    DPA_OP_INT_SUB = 5'h08,
    DPA_OP_INT_CROSS_SUB = 5'h10
  } dpa_op_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    dpa_op_t op;
    logic [DPA_SEL_W-1:0] accumulator_select;
    logic [DPA_WORD_W-1:0] first_source_operand;
    logic [DPA_WORD_W-1:0] second_source_operand;
  } dpa_req_t;

  typedef struct packed {
    logic [DPA_SEL_W-1:0] accumulator_select;
    logic [DPA_ACC_W-1:0] value;
  } dpa_rsp_t;
endpackage

/* rtl/dpa_unit.sv */
// dot-product accumulate datapath with four wide accumulators

module dpa_unit #(
  parameter int unsigned ACC_NUM = dpa_pkg::DPA_ACC_NUM
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // operation request
  input wire logic req_valid,
  input wire dpa_pkg::dpa_req_t req,
  // accumulator preload
  input wire logic load_valid,
  input wire logic [dpa_pkg::DPA_SEL_W-1:0] load_sel,
  input wire logic [dpa_pkg::DPA_ACC_W-1:0] load_value,
  // result
  output logic rsp_valid,
  output dpa_pkg::dpa_rsp_t rsp,
  output logic sat_hit
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic take;
  wire logic is_frac;
  wire logic is_cross;
  wire logic is_sub;
  wire logic is_sat;
  wire logic [dpa_pkg::DPA_SEL_W-1:0] sel;
  // anything that is not one-hot decodes as a plain add
  assign take = clk_en && req_valid;
  assign is_frac = req.op == dpa_pkg::DPA_OP_FRAC_DOT || req.op == dpa_pkg::DPA_OP_FRAC_CROSS
    || req.op == dpa_pkg::DPA_OP_FRAC_CROSS_SAT;
  assign is_cross = req.op == dpa_pkg::DPA_OP_FRAC_CROSS
    || req.op == dpa_pkg::DPA_OP_FRAC_CROSS_SAT || req.op == dpa_pkg::DPA_OP_INT_CROSS_SUB;
  assign is_sub = req.op == dpa_pkg::DPA_OP_INT_SUB || req.op == dpa_pkg::DPA_OP_INT_CROSS_SUB;
  assign is_sat = req.op == dpa_pkg::DPA_OP_FRAC_CROSS_SAT;
  assign sel = req.accumulator_select;

  // ----------------------------------------
  // lane products
  // ----------------------------------------
  logic signed [31:0] prod [2];
  logic [1:0] clamp;
  for (genvar g = 0; g < 2; g++) begin : g_lane
    wire logic signed [15:0] opa;
    wire logic signed [15:0] opb;
    wire logic signed [31:0] raw;
    wire logic [15:0] first_straight;
    wire logic [15:0] first_crossed;
    assign first_straight =
      req.first_source_operand[dpa_pkg::DPA_HALF_W*g +: dpa_pkg::DPA_HALF_W];
    assign first_crossed =
      req.first_source_operand[dpa_pkg::DPA_HALF_W*(1-g) +: dpa_pkg::DPA_HALF_W];
    // lane 0 crossed: first upper by second lower; lane 1: first lower by second upper
    assign opa = is_cross ? first_crossed : first_straight;
    assign opb = req.second_source_operand[dpa_pkg::DPA_HALF_W*g +: dpa_pkg::DPA_HALF_W];
    assign raw = opa * opb;
    assign clamp[g] = is_frac && opa == dpa_pkg::DPA_Q15_MINUS_ONE
      && opb == dpa_pkg::DPA_Q15_MINUS_ONE;
    // the doubling would overflow only for -1.0 squared, hence the clamp
    assign prod[g] = clamp[g] ? dpa_pkg::DPA_Q31_MAX
      : (is_frac ? (raw <<< 1) : raw);
  end

  // ----------------------------------------
  // sum and accumulate
  // ----------------------------------------
  wire logic signed [32:0] dot_sum;
  wire logic signed [63:0] dot_ext;
  wire logic signed [63:0] acc_cur;
  wire logic signed [63:0] acc_add;
  wire logic signed [63:0] acc_sub;
  wire logic over_pos;
  wire logic over_neg;
  wire logic signed [63:0] acc_new;
  logic signed [63:0] acc_r [ACC_NUM];

  // two clamped products fit in 33 bits, so the sum itself never wraps
  assign dot_sum = {prod[0][31], prod[0]} + {prod[1][31], prod[1]};
  assign dot_ext = {{31{dot_sum[32]}}, dot_sum};
  assign acc_cur = acc_r[sel];
  assign acc_add = acc_cur + dot_ext;
  assign acc_sub = acc_cur - dot_ext;
  // saturation bound is the Q31 range held in the wide accumulator
  assign over_pos = acc_add > $signed(dpa_pkg::DPA_SAT_POS);
  assign over_neg = acc_add < $signed(dpa_pkg::DPA_SAT_NEG);
  assign acc_new = is_sub ? acc_sub
    : (is_sat && over_pos) ? $signed(dpa_pkg::DPA_SAT_POS)
    : (is_sat && over_neg) ? $signed(dpa_pkg::DPA_SAT_NEG)
    : acc_add;

  // ----------------------------------------
  // accumulator bank
  // ----------------------------------------
  // a preload in the same cycle as a request to any accumulator is dropped
  // reset too waits for an enabled edge, so a frozen unit keeps every value
  for (genvar a = 0; a < ACC_NUM; a++) begin : g_acc
    always_ff @(posedge clk_sys) begin
      if (clk_en && !rst_n) begin
        acc_r[a] <= dpa_pkg::DPA_ACC_RST;
      end else if (take && sel == a) begin
        acc_r[a] <= acc_new;
      end else if (clk_en && !req_valid && load_valid && load_sel == a) begin
        acc_r[a] <= load_value;
      end
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // outputs hold while frozen; rsp keeps the last result until the next request
  always_ff @(posedge clk_sys) begin
    if (clk_en && !rst_n) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      sat_hit <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= req_valid;
      sat_hit <= req_valid && is_sat && (over_pos || over_neg);
      if (req_valid) begin
        rsp.accumulator_select <= sel;
        rsp.value <= acc_new;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_FRAC_DOUBLE: assert property (
    take && req.op == dpa_pkg::DPA_OP_FRAC_DOT && req.first_source_operand[31:16] == 16'h4000
      && req.second_source_operand[31:16] == 16'h4000 |-> prod[1] == 32'h2000_0000)
    else $error("fractional product not doubled");
  AST_FRAC_CLAMP: assert property (
    take && is_frac && !is_cross && req.first_source_operand[15:0] == 16'h8000
      && req.second_source_operand[15:0] == 16'h8000 |-> prod[0] == 32'h7fff_ffff)
    else $error("minus one squared not clamped");
  AST_FRAC_ACC: assert property (
    take && req.op == dpa_pkg::DPA_OP_FRAC_DOT
      |=> rsp_valid && rsp.value == $past(acc_cur) + $past(dot_ext)
      && acc_r[$past(sel)] == rsp.value)
    else $error("fractional sum not accumulated");
  AST_CROSS_WRAP: assert property (
    take && req.op == dpa_pkg::DPA_OP_FRAC_CROSS
      |=> rsp.value == $past(acc_cur) + $past(dot_ext) && !sat_hit)
    else $error("crossed accumulate must wrap");
  AST_CROSS_SAT: assert property (
    take && is_sat |=> $signed(rsp.value) <= $signed(dpa_pkg::DPA_SAT_POS)
      && $signed(rsp.value) >= $signed(dpa_pkg::DPA_SAT_NEG)
      && sat_hit == (rsp.value != $past(acc_add)))
    else $error("saturating accumulate out of range");
  AST_INT_SUB: assert property (
    take && req.op == dpa_pkg::DPA_OP_INT_SUB
      |=> rsp.value == $past(acc_cur) - $past(dot_ext) ##1 1'b1)
    else $error("integer dot not subtracted");
  AST_INT_CROSS_SUB: assert property (
    take && req.op == dpa_pkg::DPA_OP_INT_CROSS_SUB
      |=> rsp.value == $past(acc_cur) - $past(dot_ext) && acc_r[$past(sel)] == rsp.value)
    else $error("crossed integer dot not subtracted");
  AST_CROSS_PAIR: assert property (
    take && req.op == dpa_pkg::DPA_OP_INT_CROSS_SUB
      |-> prod[0] == $signed(req.first_source_operand[31:16])
        * $signed(req.second_source_operand[15:0]))
    else $error("crossed pairing wrong");

  // ----------------------------------------
  // checks on lanes, flags, preload and freeze
  // ----------------------------------------
  AST_CROSS_CLAMP: assert property (
    take && req.op == dpa_pkg::DPA_OP_FRAC_CROSS && req.first_source_operand[31:16] == 16'h8000
      && req.second_source_operand[15:0] == 16'h8000 |-> prod[0] == 32'h7fff_ffff)
    else $error("crossed minus one squared not clamped");
  AST_INT_NO_CLAMP: assert property (
    take && req.op == dpa_pkg::DPA_OP_INT_SUB && req.first_source_operand[15:0] == 16'h8000
      && req.second_source_operand[15:0] == 16'h8000 |-> prod[0] == 32'h4000_0000)
    else $error("integer product clamped or doubled");
  AST_FRAC_CROSS_PAIR: assert property (
    take && req.op == dpa_pkg::DPA_OP_FRAC_CROSS && !clamp[1]
      |-> prod[1] == ($signed(req.first_source_operand[15:0])
        * $signed(req.second_source_operand[31:16])) <<< 1)
    else $error("crossed fractional lane wrong");
  AST_INT_CROSS_LANE: assert property (
    take && req.op == dpa_pkg::DPA_OP_INT_CROSS_SUB
      |-> prod[1] == $signed(req.first_source_operand[15:0])
        * $signed(req.second_source_operand[31:16]))
    else $error("crossed integer lane wrong");
  AST_SAT_POS_CLAMP: assert property (
    take && is_sat && over_pos |=> sat_hit && rsp.value == dpa_pkg::DPA_SAT_POS)
    else $error("positive overflow not clamped");
  AST_SAT_NEG_CLAMP: assert property (
    take && is_sat && over_neg |=> sat_hit && rsp.value == dpa_pkg::DPA_SAT_NEG)
    else $error("negative overflow not clamped");
  AST_PLAIN_NO_FLAG: assert property (
    take && !is_sat |=> rsp_valid && !sat_hit && rsp.accumulator_select == $past(sel))
    else $error("flag raised by a wrapping operation");
  AST_IDLE_QUIET: assert property (
    clk_en && !req_valid |=> !rsp_valid && !sat_hit)
    else $error("response without a request");
  AST_PRELOAD_DROPPED: assert property (
    take && load_valid && load_sel != sel
      |=> acc_r[$past(load_sel)] == $past(acc_r[load_sel]))
    else $error("preload taken beside a request");
  AST_FREEZE: assert property (
    !clk_en |=> $stable(rsp_valid) && $stable(rsp) && $stable(sat_hit)
      && $stable(acc_r[0]))
    else $error("state moved while the clock enable was low");
endmodule // dpa_unit

/* dv/dpa_pipe_model.sv */
// pipeline-side request driver for the dot-product accumulate unit
module dpa_pipe_model (
  // request out
  output logic req_valid,
  output dpa_pkg::dpa_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // call just after a falling edge; idle bus inverts so stale operands never look valid
  task automatic put(input logic v, input dpa_pkg::dpa_req_t r);
    req_valid = v;
    req = v ? r : ~req;
  endtask
endmodule // dpa_pipe_model

/* dv/tb_top.sv */
// self-checking bench for the dot-product accumulate unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, clk_en, load_valid, req_valid, rsp_valid, sat_hit;
  logic [1:0] load_sel;
  logic [63:0] load_value;
  logic [63:0] acc [4];
  dpa_pkg::dpa_req_t req;
  dpa_pkg::dpa_rsp_t rsp;
  int n_mismatch, tests_run;
  dpa_pipe_model dpa_pipe_model_i (.req_valid(req_valid), .req(req));
  dpa_unit dpa_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .load_valid(load_valid), .load_sel(load_sel),
    .load_value(load_value), .rsp_valid(rsp_valid), .rsp(rsp), .sat_hit(sat_hit));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [67:0] exp, logic [67:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic signed [31:0] mul(logic [15:0] x, logic [15:0] y, logic frac);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    if (!frac) return p;
    if (x == 16'h8000 && y == 16'h8000) return 32'h7fff_ffff;
    return p <<< 1;
  endfunction
  // one op, checked one cycle later; callers may chain these back to back
  task automatic run_op(dpa_pkg::dpa_op_t op, logic [1:0] sel, logic [31:0] a, logic [31:0] b);
    logic [4:0] o;
    logic cr, fr, hit;
    logic signed [63:0] s, r;
    o = op;
    cr = o[1] | o[2] | o[4];
    fr = o[0] | o[1] | o[2];
    s = mul(a[31:16], cr ? b[15:0] : b[31:16], fr) + mul(a[15:0], cr ? b[31:16] : b[15:0], fr);
    r = fr ? acc[sel] + s : acc[sel] - s;
    hit = o[2] && (r > $signed(dpa_pkg::DPA_SAT_POS) || r < $signed(dpa_pkg::DPA_SAT_NEG));
    if (hit) r = r > 0 ? dpa_pkg::DPA_SAT_POS : dpa_pkg::DPA_SAT_NEG;
    acc[sel] = r;
    dpa_pipe_model_i.put(1'b1, '{op, sel, a, b});
    @(negedge clk_sys);
    chk("rsp", {1'b1, hit, sel, r}, {rsp_valid, sat_hit, rsp.accumulator_select, rsp.value});
  endtask
  task automatic preload(logic [1:0] sel, logic [63:0] v);
    dpa_pipe_model_i.put(1'b0, '0);
    load_valid = 1'b1;
    load_sel = sel;
    load_value = v;
    acc[sel] = v;
    @(negedge clk_sys);
    load_valid = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h7419));
    {rst_n, load_valid, load_sel, load_value, n_mismatch, tests_run} = '0;
    clk_en = 1'b1;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("reset", 68'h0, {rsp_valid, sat_hit, rsp});
    for (int i = 0; i < 4; i++) acc[i] = '0;
    for (int k = 0; k < 5; k++) run_op(dpa_pkg::dpa_op_t'(5'h01 << k), 2'(k), 32'h8000_8000,
      32'h8000_8000);
    preload(2'h1, 64'h0000_0000_7fff_0000);
    run_op(dpa_pkg::DPA_OP_FRAC_CROSS_SAT, 2'h1, 32'h7fff_7fff, 32'h7fff_7fff);
    preload(2'h1, dpa_pkg::DPA_SAT_NEG);
    run_op(dpa_pkg::DPA_OP_FRAC_CROSS_SAT, 2'h1, 32'h8000_7fff, 32'h7fff_7fff);
    for (int i = 0; i < 200; i++) begin
      if (i % 25 == 0) preload(2'($urandom), i % 50 == 0 ? 64'($signed($urandom)) :
        {$urandom, $urandom});
      run_op(dpa_pkg::dpa_op_t'(5'h01 << ($urandom % 5)), 2'($urandom), $urandom,
        $urandom);
    end
    // preload colliding with a request is dropped, the request still goes through
    load_valid = 1'b1;
    load_sel = 2'h1;
    load_value = {$urandom, $urandom};
    run_op(dpa_pkg::DPA_OP_INT_SUB, 2'h2, 32'h1234_8001, 32'hfedc_7fff);
    load_valid = 1'b0;
    run_op(dpa_pkg::DPA_OP_INT_CROSS_SUB, 2'h1, 32'h8000_0003, 32'h8000_fffd);
    run_op(dpa_pkg::DPA_OP_FRAC_DOT, 2'h3, 32'h4000_7fff, 32'h4000_8000);
    // frozen unit ignores a request and then a reset, and holds its outputs
    clk_en = 1'b0;
    dpa_pipe_model_i.put(1'b1, '{dpa_pkg::DPA_OP_INT_SUB, 2'h3, $urandom, $urandom});
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk("frozen", {2'h2, 2'h3, acc[3]}, {rsp_valid, sat_hit, rsp});
    clk_en = 1'b1;
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk("reset_mid", 68'h0, {rsp_valid, sat_hit, rsp});
    for (int i = 0; i < 4; i++) acc[i] = '0;
    run_op(dpa_pkg::DPA_OP_INT_CROSS_SUB, 2'h3, $urandom, $urandom);
    dpa_pipe_model_i.put(1'b0, '0);
    @(negedge clk_sys);
    chk("rsp_valid_idle", 68'h0, 68'(rsp_valid));
    tally_and_finish();
  end
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_top
